// *** hw/eeam_defines.svh ***
`ifndef EEAM_DEFINES_SVH
`define EEAM_DEFINES_SVH

// array placement and shape
`define EEAM_BASE_ADDR      16'hB600
`define EEAM_BASE_HI        7'h5B
`define EEAM_ROWS           32
`define EEAM_ROW_BYTES      16
`define EEAM_ARRAY_BYTES    512
`define EEAM_ERASED_BYTE    8'hFF
`define EEAM_ZERO_BYTE      8'h00

// configuration byte address, outside the array
`define EEAM_CFG_ADDR       16'hB800

// operation codes on the request
`define EEAM_OP_PROGRAM     2'h0
`define EEAM_OP_ERASE_BYTE  2'h1
`define EEAM_OP_ERASE_ROW   2'h2
`define EEAM_OP_ERASE_BULK  2'h3

// timing
`define EEAM_CLK_PERIOD_NS  10
`define EEAM_PROG_TIME_NS   10000000

`endif

// *** hw/eeam_pkg.sv ***
package eeam_pkg;

  // one bus request: operation, byte address and write data
  typedef struct packed
  {
    logic [1:0]  op;
    logic [15:0] addr;
    logic [7:0]  data;
  } eeam_req_t;

  // one-hot sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_DONE = 3'h4
  } eeam_state_t;

endpackage

// *** hw/eeam_pump_clk.sv ***
`timescale 1ns/1ns
`include "eeam_defines.svh"

// charge pump clock source selection
module eeam_pump_clk
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic pump_clock_select,
  input  wire logic pump_run,
  input  wire logic rc_osc,
  // pump drive
  output logic      pump_clk
);

  logic [2:0] rc_sync;      // three-stage synchroniser for the oscillator pin
  logic       rc_state;     // last agreed oscillator level
  logic       next_rc_state;
  logic       next_pump_clk;

  // agreed oscillator level follows stages two and three once they match
  always_comb
  begin
    next_rc_state = rc_state;
    if (rc_sync[1] == rc_sync[2])
    begin
      next_rc_state = rc_sync[2];
    end
  end

  // pump toggles from bus clock or follows the oscillator [RQ8]
  always_comb
  begin
    if (!pump_run)
    begin
      next_pump_clk = 1'b0;                     // pump idle, no switching noise
    end
    else if (pump_clock_select)
    begin
      next_pump_clk = rc_state;                 // rc oscillator drive [RQ8]
    end
    else
    begin
      next_pump_clk = ~pump_clk;                // bus clock divided by two [RQ8]
    end
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rc_sync  <= 3'h0;
      rc_state <= 1'b0;
      pump_clk <= 1'b0;
    end
    else
    begin
      rc_sync  <= {rc_sync[1:0], rc_osc};
      rc_state <= next_rc_state;
      pump_clk <= next_pump_clk;
    end
  end

endmodule

// *** hw/eeam_array.sv ***
// Notes on behaviour
// RQ1 - array decoded at fixed, non-relocatable range
// RQ2 - thirty-two rows of sixteen consecutive bytes
// RQ3 - row zero lowest, rows ascend in order
// RQ4 - erase one byte, one row, or all
// RQ5 - config byte separate, untouched by array erases
// RQ6 - software erases/reprograms, internal pump, nonvolatile storage
// RQ7 - erased bit reads one; programming only clears
// RQ8 - pump clock from bus clock or rc
// RQ9 - row index is offset bits eight to four
`timescale 1ns/1ns
`include "eeam_defines.svh"

module eeam_array
#(
  parameter int PROG_CYCLES = `EEAM_PROG_TIME_NS / `EEAM_CLK_PERIOD_NS  // erase/program dwell
)
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  // processor bus
  input  wire eeam_pkg::eeam_req_t BUS_REQ,
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  output logic [7:0]             BUS_RDATA,
  output logic                   BUS_HIT,
  // control levels
  input  wire logic              ARRAY_ENABLE_BIT,
  input  wire logic              SECURITY_DISABLE_BIT,
  input  wire logic              CFG_ERASE_UNLOCK,
  input  wire logic              PUMP_CLOCK_SELECT,
  input  wire logic              RC_OSC,
  // status
  output logic                   BUSY,
  output logic                   REFUSED,
  output logic                   PUMP_CLK,
  output logic [7:0]             CFG_BYTE
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);   // dwell counter width

  // storage; no reset on either, contents survive reset like the cells do [RQ6]
  logic [7:0]            mem [`EEAM_ARRAY_BYTES];   // the erasable array
  logic [7:0]            cfg;                       // configuration byte, kept apart [RQ5]

  eeam_pkg::eeam_state_t state;                     // sequencer state
  eeam_pkg::eeam_state_t next_state;
  eeam_pkg::eeam_req_t   op_req;                    // latched request
  eeam_pkg::eeam_req_t   next_op_req;
  logic                  op_cfg;                    // latched target is config byte
  logic                  next_op_cfg;
  logic [CNT_W-1:0]      cnt;                       // dwell counter
  logic [CNT_W-1:0]      next_cnt;
  logic [7:0]            rdata;
  logic [7:0]            next_rdata;
  logic                  hit;
  logic                  next_hit;
  logic                  refused;
  logic                  next_refused;

  // true when address lies in the fixed array window [RQ1]
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a[15:9] == `EEAM_BASE_HI);          // no relocation option [RQ1]
  endfunction

  // byte offset inside the array
  function automatic logic [8:0] offset(input logic [15:0] a);
    offset = a[8:0];
  endfunction

  // row index; low four offset bits do not matter [RQ9]
  function automatic logic [4:0] row_of(input logic [15:0] a);
    row_of = a[8:4];                                // row zero at base, rows ascend [RQ2] [RQ3]
  endfunction

  logic req_array;                                  // request hits the array
  logic req_cfg;                                    // request hits the config byte
  logic cfg_ok;                                     // config request allowed

  // decode of the current request
  always_comb
  begin
    req_array = ARRAY_ENABLE_BIT && in_array(BUS_REQ.addr);
    req_cfg   = (BUS_REQ.addr == `EEAM_CFG_ADDR);
    // config programming always allowed; its erase needs unlock and open security [RQ5]
    cfg_ok    = (BUS_REQ.op == `EEAM_OP_PROGRAM) || (CFG_ERASE_UNLOCK && SECURITY_DISABLE_BIT);
  end

  // sequencer: accept, dwell while the pump runs, then commit
  always_comb
  begin
    next_state   = state;
    next_op_req  = op_req;
    next_op_cfg  = op_cfg;
    next_cnt     = cnt;
    next_refused = 1'b0;
    case (state)
      eeam_pkg::ST_IDLE:
      begin
        if (BUS_WR && (req_array || (req_cfg && cfg_ok)))
        begin
          next_state  = eeam_pkg::ST_RUN;           // software-started operation [RQ6]
          next_op_req = BUS_REQ;
          next_op_cfg = req_cfg;
          next_cnt    = CNT_W'(PROG_CYCLES - 1);
        end
        else if (BUS_WR && req_cfg)
        begin
          next_refused = 1'b1;                      // locked config erase [RQ5]
        end
      end
      eeam_pkg::ST_RUN:
      begin
        if (BUS_WR && (req_array || req_cfg))
        begin
          next_refused = 1'b1;                      // one operation at a time
        end
        if (cnt == '0)
        begin
          next_state = eeam_pkg::ST_DONE;
        end
        else
        begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      eeam_pkg::ST_DONE:
      begin
        if (BUS_WR && (req_array || req_cfg))
        begin
          next_refused = 1'b1;
        end
        next_state = eeam_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = eeam_pkg::ST_IDLE;
      end
    endcase
  end

  // read path; array reads blocked while the sequencer is out of idle (run and done), reads as erased
  always_comb
  begin
    next_rdata = `EEAM_ZERO_BYTE;
    next_hit   = 1'b0;
    if (BUS_RD && req_array)
    begin
      next_hit   = 1'b1;
      next_rdata = (state == eeam_pkg::ST_IDLE) ? mem[offset(BUS_REQ.addr)] : `EEAM_ERASED_BYTE;
    end
    else if (BUS_RD && req_cfg)
    begin
      next_hit   = 1'b1;
      next_rdata = cfg;
    end
  end

  // control registers
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state   <= eeam_pkg::ST_IDLE;
      op_req  <= '0;
      op_cfg  <= 1'b0;
      cnt     <= '0;
      rdata   <= `EEAM_ZERO_BYTE;
      hit     <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      op_req  <= next_op_req;
      op_cfg  <= next_op_cfg;
      cnt     <= next_cnt;
      rdata   <= next_rdata;
      hit     <= next_hit;
      refused <= next_refused;
    end
  end

  // array commit; a loop writes a row or the whole array in one edge
  always_ff @(posedge CORE_CLK)
  begin
    if (state == eeam_pkg::ST_DONE && !op_cfg)
    begin
      case (op_req.op)
        `EEAM_OP_PROGRAM:
        begin
          // ones leave bits alone, zeros clear them [RQ7]
          mem[offset(op_req.addr)] <= mem[offset(op_req.addr)] & op_req.data;
        end
        `EEAM_OP_ERASE_BYTE:
        begin
          mem[offset(op_req.addr)] <= `EEAM_ERASED_BYTE;        // byte erase [RQ4] [RQ7]
        end
        `EEAM_OP_ERASE_ROW:
        begin
          for (int i = 0; i < `EEAM_ROW_BYTES; i++)
          begin
            mem[{row_of(op_req.addr), 4'(i)}] <= `EEAM_ERASED_BYTE;  // row erase [RQ4] [RQ9]
          end
        end
        `EEAM_OP_ERASE_BULK:
        begin
          for (int i = 0; i < `EEAM_ARRAY_BYTES; i++)
          begin
            mem[i] <= `EEAM_ERASED_BYTE;                         // bulk, array only [RQ4] [RQ5]
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // config commit; only a config-addressed request reaches it [RQ5]
  always_ff @(posedge CORE_CLK)
  begin
    if (state == eeam_pkg::ST_DONE && op_cfg)
    begin
      if (op_req.op == `EEAM_OP_PROGRAM)
      begin
        cfg <= cfg & op_req.data;                   // [RQ7]
      end
      else
      begin
        cfg <= `EEAM_ERASED_BYTE;                   // unlocked config erase [RQ5]
      end
    end
  end

  logic [7:0] cfg_out;                              // registered copy for the pins
  logic [7:0] next_cfg_out;

  // config byte mirror; reset loads all ones, then unknown from the first clock until the first config erase in simulation
  always_comb
  begin
    next_cfg_out = cfg;
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_out <= `EEAM_ERASED_BYTE;
    end
    else
    begin
      cfg_out <= next_cfg_out;
    end
  end

  // pump clocking, internal so no external high voltage is needed [RQ6] [RQ8]
  eeam_pump_clk u_pump
  (
    .core_clk          (CORE_CLK),
    .rst               (RST),
    .pump_clock_select (PUMP_CLOCK_SELECT),
    .pump_run          (state == eeam_pkg::ST_RUN),
    .rc_osc            (RC_OSC),
    .pump_clk          (PUMP_CLK)
  );

  // outputs
  assign BUS_RDATA = rdata;
  assign BUS_HIT   = hit;
  assign BUSY      = (state != eeam_pkg::ST_IDLE);
  assign REFUSED   = refused;
  assign CFG_BYTE  = cfg_out;

endmodule

// *** sim/eeam_array_chk.sv ***
`timescale 1ns/1ns
`include "eeam_defines.svh"

// port-level checker for the array block
module eeam_array_chk
#(
  parameter int PROG_CYCLES = 8  // dwell, handed on by the bind
)
(
  // clock and reset
  input wire logic                CORE_CLK,
  input wire logic                RST,
  // bus
  input wire eeam_pkg::eeam_req_t BUS_REQ,
  input wire logic                BUS_WR,
  input wire logic                BUS_RD,
  input wire logic [7:0]          BUS_RDATA,
  input wire logic                BUS_HIT,
  // levels and status
  input wire logic                ARRAY_ENABLE_BIT,
  input wire logic                SECURITY_DISABLE_BIT,
  input wire logic                CFG_ERASE_UNLOCK,
  input wire logic                PUMP_CLOCK_SELECT,
  input wire logic                BUSY,
  input wire logic                REFUSED,
  input wire logic                PUMP_CLK
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic        in_arr;    // address falls in the fixed array window
  logic        is_cfg;    // address is the config byte
  logic [31:0] run;       // cycles busy so far
  logic [31:0] next_run;  // next busy count

  assign in_arr = (BUS_REQ.addr[15:9] == `EEAM_BASE_HI);
  assign is_cfg = (BUS_REQ.addr == `EEAM_CFG_ADDR);

  // busy length count, cleared while idle
  always_comb
  begin
    next_run = BUSY ? run + 32'h1 : 32'h0;
  end

  // register the count
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      run <= 32'h0;
    else
      run <= next_run;
  end

  a_hit_array: assert property (BUS_RD && in_arr && ARRAY_ENABLE_BIT |=> BUS_HIT)
    else $error("array read without hit");
  a_miss_outside: assert property (BUS_RD && !in_arr && !is_cfg |=> !BUS_HIT)
    else $error("hit outside the array");
  a_miss_disabled: assert property (BUS_RD && in_arr && !ARRAY_ENABLE_BIT |=> !BUS_HIT)
    else $error("hit while array disabled");
  a_rd_quiet: assert property (!BUS_RD |=> !BUS_HIT && BUS_RDATA == 8'h00)
    else $error("read answer without read");
  a_op_start: assert property (BUS_WR && !BUSY && in_arr && ARRAY_ENABLE_BIT |=> BUSY && !REFUSED)
    else $error("array operation not started");
  a_busy_refuse: assert property (BUS_WR && BUSY && in_arr && ARRAY_ENABLE_BIT |=> REFUSED)
    else $error("write while busy not refused");
  a_busy_len: assert property ($fell(BUSY) |-> run == PROG_CYCLES + 1)
    else $error("busy length wrong");
  a_busy_read: assert property (BUS_RD && in_arr && ARRAY_ENABLE_BIT && run > 0 && run < 4
    |=> BUS_RDATA == 8'hFF)
    else $error("read during operation not erased value");
  a_cfg_locked: assert property (BUS_WR && !BUSY && is_cfg && BUS_REQ.op != 2'h0
    && !(SECURITY_DISABLE_BIT && CFG_ERASE_UNLOCK) |=> REFUSED)
    else $error("locked config erase accepted");
  a_pump_bus: assert property ($rose(BUSY) && !PUMP_CLOCK_SELECT |-> ##[1:2] PUMP_CLK ##1 !PUMP_CLK)
    else $error("pump not toggling from bus clock");
  a_pump_rest: assert property (!BUSY && !$past(BUSY) |-> !PUMP_CLK)
    else $error("pump running while idle");

  c_op: cover property ($fell(BUSY));
  c_refuse: cover property (REFUSED);
  c_hit: cover property (BUS_HIT);
endmodule

bind eeam_array eeam_array_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk
(
  .CORE_CLK(CORE_CLK), .RST(RST), .BUS_REQ(BUS_REQ), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
  .BUS_RDATA(BUS_RDATA), .BUS_HIT(BUS_HIT), .ARRAY_ENABLE_BIT(ARRAY_ENABLE_BIT),
  .SECURITY_DISABLE_BIT(SECURITY_DISABLE_BIT), .CFG_ERASE_UNLOCK(CFG_ERASE_UNLOCK),
  .PUMP_CLOCK_SELECT(PUMP_CLOCK_SELECT), .BUSY(BUSY), .REFUSED(REFUSED), .PUMP_CLK(PUMP_CLK)
);

// *** sim/eeprom_array_map_erase_tb.sv ***
`timescale 1ns/1ns

// count and judge one comparison
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module eeprom_array_map_erase_tb;
  logic                CORE_CLK, RST, BUS_WR, BUS_RD;  // clock, reset, strobes
  eeam_pkg::eeam_req_t req;                            // request fields
  logic                en, sec, unl, sel, rc;          // control levels
  logic [7:0]          rdata, cfg;                     // read data, config mirror
  logic                hit, busy, refused, pump;       // status
  logic                refd;                           // refusal seen by last write
  int                  n_errors, compares;             // counters

  // short dwell keeps the run small
  eeam_array #(.PROG_CYCLES(8)) dut
  (
    .CORE_CLK(CORE_CLK), .RST(RST), .BUS_REQ(req), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
    .BUS_RDATA(rdata), .BUS_HIT(hit), .ARRAY_ENABLE_BIT(en), .SECURITY_DISABLE_BIT(sec),
    .CFG_ERASE_UNLOCK(unl), .PUMP_CLOCK_SELECT(sel), .RC_OSC(rc), .BUSY(busy),
    .REFUSED(refused), .PUMP_CLK(pump), .CFG_BYTE(cfg)
  );

  // 100 MHz clock
  initial
  begin
    CORE_CLK = 0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // slow stand-in oscillator, derived from the bus clock at one sixth its rate
  initial
  begin
    rc = 0;
    forever
    begin
      repeat (3) @(negedge CORE_CLK);
      rc = ~rc;
    end
  end

  task report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one-cycle write strobe; refusal pulse sampled the cycle after
  task wr(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
    @(negedge CORE_CLK);
    req = '{o, a, d};
    BUS_WR = 1;
    @(negedge CORE_CLK);
    BUS_WR = 0;
    refd = refused;
  endtask

  // bounded wait for the operation to finish
  task idle;
    int i;
    for (i = 0; i < 40 && busy !== 1'b0; i++)
      @(negedge CORE_CLK);
    if (busy !== 1'b0)
    begin
      n_errors++;
      $display("BAD busy_wait exp 0 got %b", busy);
      report_and_stop;
    end
  endtask

  task op(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
    wr(o, a, d);
    idle;
  endtask

  // one read, answer checked the next cycle
  task rd(input logic [15:0] a, input logic h, input logic [7:0] d);
    @(negedge CORE_CLK);
    req.addr = a;
    BUS_RD = 1;
    @(negedge CORE_CLK);
    BUS_RD = 0;
    `CHK("hit", h, hit)
    `CHK("rdata", d, rdata)
  endtask

  task t_erase_prog;
    op(2'h3, 16'hB6A0, 8'h00);
    rd(16'hB600, 1'b1, 8'hFF);
    rd(16'hB7FF, 1'b1, 8'hFF);
    op(2'h0, 16'hB605, 8'h55);
    rd(16'hB605, 1'b1, 8'h55);
    op(2'h0, 16'hB605, 8'hF0);
    rd(16'hB605, 1'b1, 8'h50);
    $display("done erase_prog");
  endtask

  // row erase picks its row from the upper offset bits only
  task t_row;
    op(2'h0, 16'hB615, 8'h00);
    op(2'h0, 16'hB616, 8'h00);
    op(2'h0, 16'hB60F, 8'h00);
    op(2'h2, 16'hB60A, 8'h00);
    rd(16'hB605, 1'b1, 8'hFF);
    rd(16'hB60F, 1'b1, 8'hFF);
    rd(16'hB615, 1'b1, 8'h00);
    op(2'h1, 16'hB615, 8'h00);
    rd(16'hB615, 1'b1, 8'hFF);
    rd(16'hB616, 1'b1, 8'h00);
    $display("done row");
  endtask

  task t_map;
    rd(16'hB5FF, 1'b0, 8'h00);
    rd(16'hB801, 1'b0, 8'h00);
    en = 0;
    rd(16'hB616, 1'b0, 8'h00);
    wr(2'h3, 16'hB600, 8'h00);
    `CHK("busy_off", 1'b0, busy)
    en = 1;
    rd(16'hB616, 1'b1, 8'h00);
    $display("done map");
  endtask

  // config byte: locked erase refused, array erase leaves it alone
  task t_cfg;
    sec = 1;
    unl = 1;
    op(2'h1, 16'hB800, 8'h00);
    // the pin mirror trails the stored byte by one clock
    @(negedge CORE_CLK);
    `CHK("cfg_erase", 8'hFF, cfg)
    sec = 0;
    unl = 0;
    op(2'h0, 16'hB800, 8'hA5);
    @(negedge CORE_CLK);
    `CHK("cfg_prog", 8'hA5, cfg)
    op(2'h1, 16'hB800, 8'h00);
    `CHK("cfg_lock", 1'b1, refd)
    // unlock alone is not enough while security stays on
    unl = 1;
    op(2'h2, 16'hB800, 8'h00);
    `CHK("cfg_half_lock", 1'b1, refd)
    unl = 0;
    op(2'h3, 16'hB7FF, 8'h00);
    @(negedge CORE_CLK);
    `CHK("cfg_bulk", 8'hA5, cfg)
    rd(16'hB800, 1'b1, 8'hA5);
    $display("done cfg");
  endtask

  // overlapping write refused, reads mid-operation see erased value
  task t_busy;
    op(2'h0, 16'hB616, 8'h00);
    wr(2'h1, 16'hB7F0, 8'h00);
    wr(2'h0, 16'hB600, 8'h00);
    `CHK("busy_refuse", 1'b1, refd)
    rd(16'hB616, 1'b1, 8'hFF);
    idle;
    rd(16'hB600, 1'b1, 8'hFF);
    $display("done busy");
  endtask

  // pump edges during one operation, per clock source
  task t_pump(input logic s, input int lo, input int hi);
    int   i;
    int   n;
    logic p;
    n = 0;
    sel = s;
    wr(2'h1, 16'hB600, 8'h00);
    p = pump;
    for (i = 0; i < 12; i++)
    begin
      @(negedge CORE_CLK);
      if (pump !== p)
        n++;
      p = pump;
    end
    idle;
    `CHK("pump_edges", 1'b1, (n >= lo && n <= hi))
    `CHK("pump_rest", 1'b0, pump)
    $display("done pump");
  endtask

  // main sequence
  initial
  begin
    RST = 1;
    BUS_WR = 0;
    BUS_RD = 0;
    req = '0;
    en = 1;
    sec = 0;
    unl = 0;
    sel = 0;
    n_errors = 0;
    compares = 0;
    repeat (10) @(negedge CORE_CLK);
    RST = 0;
    t_erase_prog;
    t_row;
    t_map;
    t_cfg;
    t_busy;
    t_pump(1'b0, 5, 12);
    t_pump(1'b1, 1, 4);
    report_and_stop;
  end
endmodule
